// [include/core_state_pkg.sv]
// Package for the core state register block: register map, field layout,
// reset values and core operation codes.
// Assumes a 32-bit AHB-Lite register bus with one word per register.
package core_state_pkg;
	// Byte addresses of the registers on the bus
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_PUSH_PTR = 8'h04;
	localparam logic [7:0] ADDR_DP_LOW = 8'h08;
	localparam logic [7:0] ADDR_DP_HIGH = 8'h0c;
	localparam logic [7:0] ADDR_INSTR_CNT = 8'h10;
	localparam logic [7:0] ADDR_ACC = 8'h14;
	localparam logic [7:0] ADDR_BANK_BASE = 8'h18;
	localparam logic [7:0] ADDR_CODE_ADDR = 8'h1c;
	localparam logic [7:0] ADDR_EXT_ADDR = 8'h20;

	// Status word field positions
	localparam int BIT_CARRY = 7;
	localparam int BIT_HALF_CARRY = 6;
	localparam int BIT_USER_ZERO = 5;
	localparam int BIT_BANK_HI = 4;
	localparam int BIT_BANK_LO = 3;
	localparam int BIT_WRAP = 2;
	localparam int BIT_USER_ONE = 1;
	localparam int BIT_PARITY = 0;

	// Reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] PUSH_PTR_RESET = 8'h07;
	localparam logic [7:0] DP_RESET = 8'h00;
	localparam logic [15:0] INSTR_CNT_RESET = 16'h0000;
	localparam logic [7:0] ACC_RESET = 8'h00;

	// Bank size as a shift in working registers: a bank base is code shifted left by this
	localparam int BANK_SHIFT = 3;

	// Stack operation requested by the core sequencer
	typedef enum logic [1:0] {
		STK_NONE,
		STK_PUSH,
		STK_POP
	} stack_op_t;
endpackage : core_state_pkg

// [design/status_word_unit.sv]
// Status word unit: holds the flags, keeps parity over the accumulator.
// Assumes the core sequencer and the bus writer never collide on a bit in
// a way that matters; a bus write takes precedence over arithmetic results.
`timescale 1ns/1ps
`default_nettype none
module status_word_unit (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] acc_value,
	input wire logic arith_update,
	input wire logic carry_in,
	input wire logic half_carry_in,
	input wire logic wrap_in,
	input wire logic sw_write,
	input wire logic [7:0] sw_data,
	output logic [7:0] program_status_word
);
	import core_state_pkg::*;

	logic [7:0] flags_q;
	logic [7:0] flags_d;

	// Arithmetic flags, user flags and bank select; parity is recomputed
	always_comb begin
		flags_d = flags_q;
		if (sw_write) begin
			flags_d = sw_data;
		end else if (arith_update) begin
			flags_d[BIT_CARRY] = carry_in;
			flags_d[BIT_HALF_CARRY] = half_carry_in;
			flags_d[BIT_WRAP] = wrap_in;
		end
		// User flags are only touched by software writes
		flags_d[BIT_PARITY] = 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags_q <= STATUS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Parity always follows the accumulator, software cannot override it
	always_comb begin
		program_status_word = flags_q;
		program_status_word[BIT_PARITY] = ^acc_value;
	end
endmodule : status_word_unit
`default_nettype wire

// [design/push_pointer_unit.sv]
// Push pointer unit: 8-bit stack pointer with pre-increment push.
// Assumes push and pop requests come one per cycle from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module push_pointer_unit (
	input wire logic sys_clk,
	input wire logic rst,
	input wire core_state_pkg::stack_op_t stack_op,
	input wire logic sw_write,
	input wire logic [7:0] sw_data,
	output logic [7:0] push_pointer,
	output logic [7:0] push_addr
);
	import core_state_pkg::*;

	logic [7:0] ptr_q;
	logic [7:0] ptr_d;

	// Software load wins; arithmetic wraps modulo 256 with no trap
	always_comb begin
		ptr_d = ptr_q;
		if (sw_write) begin
			ptr_d = sw_data;
		end else begin
			case (stack_op)
				STK_PUSH: ptr_d = ptr_q + 8'h01;
				STK_POP: ptr_d = ptr_q - 8'h01;
				default: ptr_d = ptr_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ptr_q <= PUSH_PTR_RESET;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	assign push_pointer = ptr_q;
	// Pushed byte lands at the already incremented address
	assign push_addr = ptr_q + 8'h01;
endmodule : push_pointer_unit
`default_nettype wire

// [design/core_state_regs.sv]
// Core architectural state: status word, push pointer, data pointer,
// instruction counter and accumulator, with an AHB-Lite register view.
// Assumes the core sequencer drives its strobes synchronously to sys_clk
// and that the bus master issues single word transfers only.
`timescale 1ns/1ps
`default_nettype none
module core_state_regs (
	input wire logic sys_clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core sequencer side
	input wire logic acc_load,
	input wire logic [7:0] acc_in,
	input wire logic arith_update,
	input wire logic carry_in,
	input wire logic half_carry_in,
	input wire logic wrap_in,
	input wire core_state_pkg::stack_op_t stack_op,
	input wire logic fetch_step,
	input wire logic jump_load,
	input wire logic [15:0] jump_target,
	input wire logic dp_load,
	input wire logic [15:0] dp_in,
	input wire logic code_table_read,
	input wire logic ext_data_access,
	// State views to the core
	output logic [7:0] program_status_word,
	output logic [7:0] push_pointer,
	output logic [7:0] push_addr,
	output logic [4:0] bank_base,
	output logic [15:0] data_pointer_word,
	output logic [15:0] instr_counter,
	output logic [15:0] code_addr,
	output logic [15:0] ext_addr
);
	import core_state_pkg::*;

	// Bus address phase capture
	logic wr_pend_q, wr_pend_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	logic take;
	logic [7:0] a_addr;

	// Software write strobes in the data phase
	logic wr_status, wr_ptr, wr_dpl, wr_dph, wr_pc, wr_acc;
	logic [7:0] wbyte;

	// Internal state
	logic [7:0] acc_q, acc_d;
	logic [7:0] dpl_q, dpl_d;
	logic [7:0] dph_q, dph_d;
	logic [15:0] pc_q, pc_d;
	logic [15:0] code_q, code_d;
	logic [15:0] ext_q, ext_d;
	logic [7:0] psw_w, ptr_w, paddr_w;
	logic [7:0] psw_q, ptr_q, paddr_q;
	logic [4:0] bank_q, bank_d;

	assign take = hsel && hready && htrans[1];
	assign a_addr = haddr[7:0];
	assign wbyte = hwdata[7:0];

	// Decode of the pending write, done in the data phase
	always_comb begin
		wr_status = wr_pend_q && (addr_q == ADDR_STATUS);
		wr_ptr = wr_pend_q && (addr_q == ADDR_PUSH_PTR);
		wr_dpl = wr_pend_q && (addr_q == ADDR_DP_LOW);
		wr_dph = wr_pend_q && (addr_q == ADDR_DP_HIGH);
		wr_pc = wr_pend_q && (addr_q == ADDR_INSTR_CNT);
		wr_acc = wr_pend_q && (addr_q == ADDR_ACC);
	end

	status_word_unit u_status (
		.sys_clk(sys_clk),
		.rst(rst),
		.acc_value(acc_q),
		.arith_update(arith_update),
		.carry_in(carry_in),
		.half_carry_in(half_carry_in),
		.wrap_in(wrap_in),
		.sw_write(wr_status),
		.sw_data(wbyte),
		.program_status_word(psw_w)
	);

	push_pointer_unit u_push (
		.sys_clk(sys_clk),
		.rst(rst),
		.stack_op(stack_op),
		.sw_write(wr_ptr),
		.sw_data(wbyte),
		.push_pointer(ptr_w),
		.push_addr(paddr_w)
	);

	// Bus slave: zero wait states, unmapped reads return zero
	always_comb begin
		wr_pend_d = take && hwrite;
		addr_d = take ? a_addr : addr_q;
		rdata_d = rdata_q;
		if (take && !hwrite) begin
			case (a_addr)
				ADDR_STATUS: rdata_d = {24'h000000, psw_w};
				ADDR_PUSH_PTR: rdata_d = {24'h000000, ptr_w};
				ADDR_DP_LOW: rdata_d = {24'h000000, dpl_q};
				ADDR_DP_HIGH: rdata_d = {24'h000000, dph_q};
				ADDR_INSTR_CNT: rdata_d = {16'h0000, pc_q};
				ADDR_ACC: rdata_d = {24'h000000, acc_q};
				ADDR_BANK_BASE: rdata_d = {27'h0000000, bank_q};
				ADDR_CODE_ADDR: rdata_d = {16'h0000, code_q};
				ADDR_EXT_ADDR: rdata_d = {16'h0000, ext_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
		end
	end

	// Accumulator, data pointer halves and instruction counter
	always_comb begin
		acc_d = acc_q;
		if (wr_acc) begin
			acc_d = wbyte;
		end else if (acc_load) begin
			acc_d = acc_in;
		end
		dpl_d = dpl_q;
		dph_d = dph_q;
		if (dp_load) begin
			dpl_d = dp_in[7:0];
			dph_d = dp_in[15:8];
		end
		if (wr_dpl) begin
			dpl_d = wbyte;
		end
		if (wr_dph) begin
			dph_d = wbyte;
		end
		pc_d = pc_q;
		if (wr_pc) begin
			pc_d = hwdata[15:0];
		end else if (jump_load) begin
			pc_d = jump_target;
		end else if (fetch_step) begin
			pc_d = pc_q + 16'h0001;
		end
	end

	// Code table reads use data pointer plus accumulator; external data
	// accesses use the data pointer alone
	always_comb begin
		code_d = {dph_q, dpl_q} + {8'h00, acc_q};
		ext_d = {dph_q, dpl_q};
		if (!code_table_read) begin
			code_d = code_q;
		end
		if (!ext_data_access) begin
			ext_d = ext_q;
		end
		bank_d = {psw_w[BIT_BANK_HI:BIT_BANK_LO], 3'b000};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_q <= ACC_RESET;
			dpl_q <= DP_RESET;
			dph_q <= DP_RESET;
			pc_q <= INSTR_CNT_RESET;
			code_q <= 16'h0000;
			ext_q <= 16'h0000;
			bank_q <= 5'h00;
			psw_q <= STATUS_RESET;
			ptr_q <= PUSH_PTR_RESET;
			paddr_q <= PUSH_PTR_RESET + 8'h01;
		end else begin
			acc_q <= acc_d;
			dpl_q <= dpl_d;
			dph_q <= dph_d;
			pc_q <= pc_d;
			code_q <= code_d;
			ext_q <= ext_d;
			bank_q <= bank_d;
			psw_q <= psw_w;
			ptr_q <= ptr_w;
			paddr_q <= paddr_w;
		end
	end

	// Registered outputs; status word, push pointer, push address and bank views trail the internal state by one cycle
	assign program_status_word = psw_q;
	assign push_pointer = ptr_q;
	assign push_addr = paddr_q;
	assign bank_base = bank_q;
	assign data_pointer_word = {dph_q, dpl_q};
	assign instr_counter = pc_q;
	assign code_addr = code_q;
	assign ext_addr = ext_q;
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
endmodule : core_state_regs
`default_nettype wire

// [tb/core_state_regs_props.sv]
// Checker of the core state block, bound to its top module.
// Assumes checked strobes never share a cycle with a bus write.
`timescale 1ns/1ps
`default_nettype none
module core_state_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic acc_load,
	input wire logic [7:0] acc_in,
	input wire core_state_pkg::stack_op_t stack_op,
	input wire logic fetch_step,
	input wire logic jump_load,
	input wire logic ext_data_access,
	input wire logic [7:0] program_status_word,
	input wire logic [7:0] push_pointer,
	input wire logic [7:0] push_addr,
	input wire logic [4:0] bank_base,
	input wire logic [15:0] data_pointer_word,
	input wire logic [15:0] instr_counter,
	input wire logic [15:0] ext_addr
);
	import core_state_pkg::*;
	logic wr_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Write data phase in flight: a bus write beats core strobes
	always_ff @(posedge sys_clk) begin
		wr_q <= !rst && hsel && hready && htrans[1] && hwrite;
	end
	reset_view_a:
	assert property ($fell(rst) |-> push_pointer == 8'h07
		&& instr_counter == 16'h0000) else $error("reset view wrong");
	push_step_a:
	assert property (stack_op == STK_PUSH && !wr_q |=> ##1 push_pointer
		== $past(push_pointer) + 8'h01) else $error("push step wrong");
	pop_wrap_a:
	assert property (stack_op == STK_POP && !wr_q |=> ##1 push_pointer
		== $past(push_pointer) - 8'h01) else $error("pop step wrong");
	push_slot_a:
	assert property (push_addr == push_pointer + 8'h01)
		else $error("push slot wrong");
	bank_map_a:
	assert property (bank_base == {program_status_word[4:3], 3'b000})
		else $error("bank base wrong");
	parity_bit_a:
	assert property ((acc_load && !wr_q) ##1 (!acc_load && !wr_q)[*3] |->
		program_status_word[0] == ^$past(acc_in, 3)) else $error("parity");
	// Counter, data pointer and captured addresses have no view lag
	count_step_a:
	assert property (fetch_step && !jump_load && !wr_q |=> instr_counter
		== $past(instr_counter) + 16'h0001) else $error("count step");
	ext_addr_a:
	assert property (ext_data_access |=> ext_addr ==
		$past(data_pointer_word)) else $error("ext address wrong");
endmodule : core_state_props
bind core_state_regs core_state_props core_state_props_i (.sys_clk, .rst,
	.hsel, .htrans, .hwrite, .hready, .acc_load, .acc_in, .stack_op,
	.fetch_step, .jump_load, .ext_data_access, .program_status_word,
	.push_pointer, .push_addr, .bank_base, .data_pointer_word,
	.instr_counter, .ext_addr);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the core state block, random with corners.
// Assumes a zero wait state bus and a one cycle lag on the status word, push pointer, push address and bank views.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import core_state_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hsel, hwrite, hready, hresp, hreadyout, acc_load, arith_update;
	logic carry_in, half_carry_in, wrap_in, fetch_step, jump_load, dp_load;
	logic code_table_read, ext_data_access;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, seed, rd, w;
	logic [7:0] acc_in, program_status_word, push_pointer, push_addr, acc, s;
	logic [4:0] bank_base;
	logic [15:0] jump_target, dp_in, data_pointer_word, instr_counter;
	logic [15:0] code_addr, ext_addr;
	stack_op_t stack_op;
	int err_total = 0;
	int samples_checked = 0;
	assign hready = hreadyout;
	core_state_regs core_state_regs_i (.*);
	// 200 MHz clock
	always #2.5 sys_clk = ~sys_clk;
	// Xorshift source, repeatable from the fixed seed
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic check(input string name, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask : check
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// Bounded wait for hready; a stuck bus ends the run
	task automatic wait_rdy();
		int n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (hready !== 1'b1) begin
			err_total++;
			end_of_test();
		end
	endtask : wait_rdy
	// Single word transfer; read data lands in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{hsel, haddr, htrans, hwrite} <= {1'b1, 24'h0, a, 2'b10, wr};
		wait_rdy();
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		wait_rdy();
		rd = hrdata;
		check("hresp", 32'h0, {31'h0, hresp});
	endtask : bus
	task automatic stk(input stack_op_t op, input int n);
		@(posedge sys_clk);
		stack_op <= op;
		tick(n);
		stack_op <= STK_NONE;
		tick(2);
	endtask : stk
	initial begin
		{hsel, hwrite, acc_load, arith_update, carry_in, half_carry_in} = '0;
		{wrap_in, fetch_step, jump_load, dp_load, code_table_read} = '0;
		{ext_data_access, htrans, hsize, haddr, hwdata} = {3'b000, 3'b010, 64'h0};
		{acc_in, jump_target, dp_in} = '0;
		stack_op = STK_NONE;
		seed = 32'h4405655d;
		tick(8);
		rst <= 1'b0;
		// Reset values, last one an unmapped place
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, (i == 6) ? 8'h40 : 8'(i * 4), 32'h0);
			check("reset read", (i == 1) ? 32'h07 : 32'h0, rd);
		end
		stk(STK_PUSH, 1);
		check("first push", 32'h08, push_pointer);
		// Every bank code with random user flags and accumulator
		for (int b = 0; b < 4; b++) begin
			w = rnd();
			w[4:3] = b[1:0];
			acc = w[15:8];
			bus(1'b1, ADDR_ACC, {24'h0, acc});
			bus(1'b1, ADDR_STATUS, w);
			s = {w[7:1], ^acc};
			tick(2);
			check("status", s, program_status_word);
			check("bank", {b[1:0], 3'b000}, bank_base);
		end
		// Flags and accumulator load share one cycle
		w = rnd();
		@(posedge sys_clk);
		{carry_in, half_carry_in, wrap_in, arith_update, acc_load} <= {w[2:0], 2'b11};
		acc_in <= w[15:8];
		@(posedge sys_clk);
		{arith_update, acc_load} <= 2'b00;
		tick(3);
		s = {w[2:1], s[5:3], w[0], s[1], ^w[15:8]};
		acc = w[15:8];
		check("flags", s, program_status_word);
		bus(1'b1, ADDR_PUSH_PTR, 32'hfe);
		stk(STK_PUSH, 2);
		check("push wrap", 32'h00, push_pointer);
		check("push slot", 32'h01, push_addr);
		stk(STK_POP, 1);
		check("pop wrap", 32'hff, push_pointer);
		w = rnd();
		bus(1'b1, ADDR_DP_LOW, {24'h0, w[7:0]});
		bus(1'b1, ADDR_DP_HIGH, {24'h0, w[15:8]});
		tick(2);
		check("data_pointer_word halves", w[15:0], data_pointer_word);
		@(posedge sys_clk);
		{dp_in, dp_load} <= {w[31:16], 1'b1};
		@(posedge sys_clk);
		{dp_load, code_table_read, ext_data_access} <= 3'b011;
		@(posedge sys_clk);
		{code_table_read, ext_data_access} <= 2'b00;
		tick(2);
		check("ext addr", w[31:16], ext_addr);
		// The sum wraps at 16 bits like the captured address
		check("code addr", {16'h0, 16'(w[31:16] + {8'h0, acc})}, code_addr);
		@(posedge sys_clk);
		fetch_step <= 1'b1;
		tick(w[3:0] + 1);
		fetch_step <= 1'b0;
		tick(2);
		check("count", w[3:0] + 1, instr_counter);
		@(posedge sys_clk);
		{jump_target, jump_load} <= {16'hffff, 1'b1};
		@(posedge sys_clk);
		{jump_load, fetch_step} <= 2'b01;
		@(posedge sys_clk);
		fetch_step <= 1'b0;
		tick(2);
		check("count wrap", 32'h0, instr_counter);
		// Second reset in mid-run
		rst <= 1'b1;
		tick(4);
		rst <= 1'b0;
		tick(2);
		check("reset ptr", 32'h07, push_pointer);
		check("reset status", 32'h0, program_status_word);
		bus(1'b0, ADDR_PUSH_PTR, 32'h0);
		check("reset ptr read", 32'h07, rd);
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
